/* File: shared/daa_regs_pkg.sv */
package daa_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_CHIP_ID = 6'h0d;
  localparam logic [5:0] IDX_CHECK_STATUS = 6'h0e;
  localparam logic [5:0] IDX_GAIN_CTRL = 6'h0f;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h11;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h12;

  localparam logic [7:0] CHECK_STATUS_RESET = 8'h04;
  localparam logic [7:0] GAIN_CTRL_RESET = 8'h00;
  localparam logic [1:0] LEGACY_RESET = 2'h0;

  // Chip identification fields.
  localparam int ID_INTL_BIT = 6;
  localparam int ID_REV_LSB = 2;
  localparam int ID_LEG_RX_BIT = 1;
  localparam int ID_LEG_TX_BIT = 0;

  // Check status fields.
  localparam int CHK_PENDING_BIT = 2;
  localparam int CHK_BUSY_BIT = 1;
  localparam int CHK_FAIL_BIT = 0;

  // Gain control fields.
  localparam int GC_TX_MUTE_BIT = 7;
  localparam int GC_TX_ATTEN_LSB = 4;
  localparam int GC_RX_MUTE_BIT = 3;
  localparam int GC_RX_GAIN_LSB = 0;

  // Interrupt status bits.
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;

  // Gain steps in dB and monitor attenuation in tenths of a dB.
  localparam logic [4:0] STEP_DB = 5'h03;
  localparam logic [4:0] TOP_DB = 5'h0c;
  localparam logic [4:0] LEGACY_RX_DB = 5'h06;
  localparam logic [4:0] LEGACY_TX_DB = 5'h03;
  localparam logic [5:0] MON_TENTHS_1 = 6'h0a;
  localparam logic [5:0] MON_TENTHS_2 = 6'h16;
  localparam logic [5:0] MON_TENTHS_3 = 6'h23;
  localparam logic [5:0] MON_TENTHS_TOP = 6'h32;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Duration of the line-side part check.
  localparam int CLK_PERIOD_NS = 100;
  localparam int CHECK_TIME_NS = 2000;
  localparam int CHECK_CYCLES = (CHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHECK_CNT_W = 5;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0] strb;
  } reg_write_s;

  typedef struct packed {
    logic line_enable;
    logic part_ok;
    logic intl;
    logic [3:0] rev;
  } line_pins_s;

  typedef struct packed {
    logic tx_mute;
    logic rx_mute;
    logic [4:0] tx_atten_db;
    logic [4:0] rx_gain_db;
    logic [5:0] mon_atten_tenths;
  } analog_ctrl_s;

endpackage

/* File: verilog/axil_reg_slave.sv */
`timescale 1ns/1ps
module axil_reg_slave
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Write channels
  input wire logic [daa_regs_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [daa_regs_pkg::DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // Read channels
  input wire logic [daa_regs_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [daa_regs_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Register file side
  output logic o_wr_en,
  output daa_regs_pkg::reg_write_s o_wr,
  input wire logic i_wr_err,
  input wire logic [daa_regs_pkg::DATA_W-1:0] i_rd_data,
  input wire logic i_rd_err
);

  logic aw_got_reg;
  logic w_got_reg;
  daa_regs_pkg::reg_write_s wr_reg;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic b_done;
  logic r_done;

  assign aw_take = i_awvalid && o_awready;
  assign w_take = i_wvalid && o_wready;
  assign ar_take = i_arvalid && o_arready;
  assign b_done = o_bvalid && i_bready;
  assign r_done = o_rvalid && i_rready;
  // Address and data are committed together once both have arrived.
  assign o_wr_en = aw_got_reg && w_got_reg && !o_bvalid;
  assign o_wr = wr_reg;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      wr_reg <= '0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= daa_regs_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        wr_reg.addr <= i_awaddr;
        aw_got_reg <= 1'b1;
        o_awready <= 1'b0;
      end
      if (w_take)
      begin
        wr_reg.data <= i_wdata;
        wr_reg.strb <= i_wstrb;
        w_got_reg <= 1'b1;
        o_wready <= 1'b0;
      end
      if (o_wr_en)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= i_wr_err ? daa_regs_pkg::RESP_SLVERR : daa_regs_pkg::RESP_OKAY;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
      if (b_done)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= daa_regs_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= i_rd_data;
      o_rresp <= i_rd_err ? daa_regs_pkg::RESP_SLVERR : daa_regs_pkg::RESP_OKAY;
    end
    else if (r_done)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
    end
  end

endmodule // axil_reg_slave

/* File: verilog/line_part_check.sv */
`timescale 1ns/1ps
module line_part_check
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Trigger and line-side answer
  input wire logic i_start,
  input wire logic i_part_ok,
  // Status
  output logic o_pending,
  output logic o_busy,
  output logic o_fail,
  output logic o_done
);

  typedef enum logic [1:0] {CHECK_IDLE, CHECK_RUN, CHECK_DONE} check_state_e;

  check_state_e state_reg;
  logic [daa_regs_pkg::CHECK_CNT_W-1:0] count_reg;
  logic count_end;

  assign count_end = count_reg == daa_regs_pkg::CHECK_CNT_W'(daa_regs_pkg::CHECK_CYCLES - 1);

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state_reg <= CHECK_IDLE;
      count_reg <= '0;
      o_pending <= 1'b1;
      o_busy <= 1'b0;
      o_fail <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      case (state_reg)
        CHECK_IDLE:
        begin
          if (i_start)
          begin
            state_reg <= CHECK_RUN;
            count_reg <= '0;
            o_busy <= 1'b1;
          end
        end
        CHECK_RUN:
        begin
          count_reg <= count_reg + 1'b1;
          if (count_end)
          begin
            state_reg <= CHECK_DONE;
            o_busy <= 1'b0;
            o_pending <= 1'b0;
            o_fail <= !i_part_ok;
            o_done <= 1'b1;
          end
        end
        CHECK_DONE:
        begin
          state_reg <= CHECK_DONE;
        end
        default:
        begin
          state_reg <= CHECK_IDLE;
        end
      endcase
    end
  end

endmodule // line_part_check

/* File: verilog/daa_gain_line_check_regs.sv */
// Functional notes
// [R1] Bit 6 of the chip identification register reads the line chip's international flag, read only.
// [R2] Bits 5:2 of the chip identification register read the line chip's four-bit revision, read only.
// [R3] The legacy receive gain bit adds 6 dB of receive gain when set and nothing when clear.
// [R4] The legacy transmit attenuation bit adds 3 dB of transmit attenuation when set and nothing when clear.
// [R5] Software keeps the legacy receive gain bit at 0 when it uses the three-bit receive gain field.
// [R6] Software keeps the legacy transmit attenuation bit at 0 when it uses the three-bit attenuation field.
// [R7] The first time the line side is enabled an automatic check of the line chip's identity is run.
// [R8] The check-pending bit resets to 1 and reads 0 once the check has been done.
// [R9] The check-in-progress bit reads 1 while the check runs and 0 otherwise.
// [R10] Software trusts the result bit only when the pending and in-progress bits are both clear.
// [R11] The result bit reads 0 for a correct line chip; when 1, registers work but sample transfer is blocked.
// [R12] The transmit mute bit mutes the transmit signal when set.
// [R13] The transmit attenuation field gives 0, 3, 6, 9 dB for codes 0 to 3 and 12 dB with the top bit set.
// [R14] The receive mute bit mutes the receive signal when set.
// [R15] The receive field gives 0, 3, 6, 9 dB of gain for codes 0 to 3 and 12 dB with the top bit set.
// [R16] For the on-hook monitor the receive field gives 0, 1, 2.2, 3.5 dB and 5 dB with the top bit set.
// [R17] Reserved bit positions read as zero and writes to them are ignored.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module daa_gain_line_check_regs
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // AXI4-Lite write channels
  input wire logic [daa_regs_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [daa_regs_pkg::DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read channels
  input wire logic [daa_regs_pkg::ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [daa_regs_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Line-side chip pins
  input wire logic i_line_enable,
  input wire logic i_line_part_ok,
  input wire logic i_line_chip_intl_flag,
  input wire logic [3:0] i_line_chip_revision,
  // Analog path controls
  output logic o_tx_mute,
  output logic o_rx_mute,
  output logic [4:0] o_tx_atten_db,
  output logic [4:0] o_rx_gain_db,
  output logic [5:0] o_mon_atten_tenths,
  output logic o_sample_xfer_en,
  // Interrupt
  output logic o_irq
);

  // Three-bit step code to dB: codes 0 to 3 in steps, any code with the top bit at the top value.
  function automatic logic [4:0] step_db(input logic [2:0] code);
    logic [4:0] result;
    result = daa_regs_pkg::TOP_DB;
    case (code[1:0])
      2'h0: result = 5'h00;
      2'h1: result = daa_regs_pkg::STEP_DB;
      2'h2: result = 5'(daa_regs_pkg::STEP_DB + daa_regs_pkg::STEP_DB);
      2'h3: result = 5'(daa_regs_pkg::STEP_DB + daa_regs_pkg::STEP_DB + daa_regs_pkg::STEP_DB);
      default: result = daa_regs_pkg::TOP_DB;
    endcase
    if (code[2])
    begin
      result = daa_regs_pkg::TOP_DB;
    end
    return result;
  endfunction

  function automatic logic [5:0] mon_tenths(input logic [2:0] code);
    logic [5:0] result;
    result = daa_regs_pkg::MON_TENTHS_TOP;
    case (code)
      3'h0: result = 6'h00;
      3'h1: result = daa_regs_pkg::MON_TENTHS_1;
      3'h2: result = daa_regs_pkg::MON_TENTHS_2;
      3'h3: result = daa_regs_pkg::MON_TENTHS_3;
      default: result = daa_regs_pkg::MON_TENTHS_TOP;
    endcase
    return result;
  endfunction

  // Word index of a byte address; the low two bits select nothing.
  function automatic logic [5:0] word_index(input logic [daa_regs_pkg::ADDR_W-1:0] addr);
    return addr[daa_regs_pkg::ADDR_W-1:2];
  endfunction

  function automatic logic is_mapped(input logic [5:0] idx);
    return idx == daa_regs_pkg::IDX_CHIP_ID || idx == daa_regs_pkg::IDX_CHECK_STATUS ||
      idx == daa_regs_pkg::IDX_GAIN_CTRL || idx == daa_regs_pkg::IDX_IRQ_STATUS ||
      idx == daa_regs_pkg::IDX_IRQ_CLEAR || idx == daa_regs_pkg::IDX_IRQ_ENABLE;
  endfunction

  // Bus slave.
  logic wr_en;
  daa_regs_pkg::reg_write_s wr;
  logic wr_err;
  logic [daa_regs_pkg::DATA_W-1:0] rd_data;
  logic rd_err;

  axil_reg_slave u_bus
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_wr_en(wr_en),
    .o_wr(wr),
    .i_wr_err(wr_err),
    .i_rd_data(rd_data),
    .i_rd_err(rd_err)
  );

  // Pin synchronisers; only the second stage is read.
  daa_regs_pkg::line_pins_s pins_meta_reg;
  daa_regs_pkg::line_pins_s pins_reg;
  daa_regs_pkg::line_pins_s pins_raw;
  logic enable_seen_reg;

  assign pins_raw.line_enable = i_line_enable;
  assign pins_raw.part_ok = i_line_part_ok;
  assign pins_raw.intl = i_line_chip_intl_flag;
  assign pins_raw.rev = i_line_chip_revision;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      pins_meta_reg <= '0;
      pins_reg <= '0;
      enable_seen_reg <= 1'b0;
    end
    else
    begin
      pins_meta_reg <= pins_raw;
      pins_reg <= pins_meta_reg;
      enable_seen_reg <= enable_seen_reg || pins_reg.line_enable;
    end
  end

  // Only the first enable after reset starts the check.
  logic check_start;
  logic check_pending;
  logic check_busy;
  logic check_fail;
  logic check_done;

  assign check_start = pins_reg.line_enable && !enable_seen_reg; // [R7]

  line_part_check u_check
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_start(check_start),
    .i_part_ok(pins_reg.part_ok),
    .o_pending(check_pending),
    .o_busy(check_busy),
    .o_fail(check_fail),
    .o_done(check_done)
  );

  // Register write decode.
  logic [5:0] wr_idx;
  logic wr_lane0;
  logic wr_chip_id;
  logic wr_gain;
  logic wr_irq_clear;
  logic wr_irq_enable;

  assign wr_idx = word_index(wr.addr);
  assign wr_lane0 = wr_en && wr.strb[0];
  assign wr_err = !is_mapped(wr_idx);
  assign wr_chip_id = wr_lane0 && wr_idx == daa_regs_pkg::IDX_CHIP_ID;
  assign wr_gain = wr_lane0 && wr_idx == daa_regs_pkg::IDX_GAIN_CTRL;
  assign wr_irq_clear = wr_lane0 && wr_idx == daa_regs_pkg::IDX_IRQ_CLEAR;
  assign wr_irq_enable = wr_lane0 && wr_idx == daa_regs_pkg::IDX_IRQ_ENABLE;

  // Software-written state.
  logic [1:0] legacy_reg;
  logic [1:0] legacy_next;
  logic [daa_regs_pkg::REG_W-1:0] gain_reg;
  logic [daa_regs_pkg::REG_W-1:0] gain_next;
  logic [daa_regs_pkg::IRQ_W-1:0] irq_enable_reg;
  logic [daa_regs_pkg::IRQ_W-1:0] irq_enable_next;
  logic [daa_regs_pkg::IRQ_W-1:0] irq_status_reg;
  logic [daa_regs_pkg::IRQ_W-1:0] irq_status_next;
  logic [daa_regs_pkg::IRQ_W-1:0] irq_events;

  // Reserved bits of the identification register are not stored.
  assign legacy_next = wr_chip_id ? wr.data[daa_regs_pkg::ID_LEG_RX_BIT:daa_regs_pkg::ID_LEG_TX_BIT] :
    legacy_reg; // [R17]
  assign gain_next = wr_gain ? wr.data[daa_regs_pkg::REG_W-1:0] : gain_reg;
  assign irq_enable_next = wr_irq_enable ? wr.data[daa_regs_pkg::IRQ_W-1:0] : irq_enable_reg;
  assign irq_events[daa_regs_pkg::IRQ_DONE_BIT] = check_done;
  assign irq_events[daa_regs_pkg::IRQ_FAIL_BIT] = check_done && check_fail; // [R11]
  // A new event in the clearing cycle wins over the clear.
  assign irq_status_next = (irq_status_reg & ~(wr_irq_clear ? wr.data[daa_regs_pkg::IRQ_W-1:0] :
    {daa_regs_pkg::IRQ_W{1'b0}})) | irq_events;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      legacy_reg <= daa_regs_pkg::LEGACY_RESET;
      gain_reg <= daa_regs_pkg::GAIN_CTRL_RESET;
      irq_enable_reg <= '0;
      irq_status_reg <= '0;
    end
    else
    begin
      legacy_reg <= legacy_next;
      gain_reg <= gain_next;
      irq_enable_reg <= irq_enable_next;
      irq_status_reg <= irq_status_next;
    end
  end

  // Register read images.
  logic [daa_regs_pkg::REG_W-1:0] chip_id_image;
  logic [daa_regs_pkg::REG_W-1:0] check_image;
  logic [5:0] rd_idx;

  always_comb
  begin
    chip_id_image = '0; // [R17]
    chip_id_image[daa_regs_pkg::ID_INTL_BIT] = pins_reg.intl; // [R1]
    chip_id_image[daa_regs_pkg::ID_REV_LSB +: 4] = pins_reg.rev; // [R2]
    chip_id_image[daa_regs_pkg::ID_LEG_RX_BIT] = legacy_reg[1];
    chip_id_image[daa_regs_pkg::ID_LEG_TX_BIT] = legacy_reg[0];
  end

  always_comb
  begin
    check_image = '0; // [R17]
    check_image[daa_regs_pkg::CHK_PENDING_BIT] = check_pending; // [R8]
    check_image[daa_regs_pkg::CHK_BUSY_BIT] = check_busy; // [R9]
    check_image[daa_regs_pkg::CHK_FAIL_BIT] = check_fail; // [R11]
  end

  assign rd_idx = word_index(i_araddr);
  assign rd_err = !is_mapped(rd_idx);

  // The clear register is write only and reads as zero.
  always_comb
  begin
    rd_data = '0;
    case (rd_idx)
      daa_regs_pkg::IDX_CHIP_ID: rd_data[daa_regs_pkg::REG_W-1:0] = chip_id_image;
      daa_regs_pkg::IDX_CHECK_STATUS: rd_data[daa_regs_pkg::REG_W-1:0] = check_image;
      daa_regs_pkg::IDX_GAIN_CTRL: rd_data[daa_regs_pkg::REG_W-1:0] = gain_reg;
      daa_regs_pkg::IDX_IRQ_STATUS: rd_data[daa_regs_pkg::IRQ_W-1:0] = irq_status_reg;
      daa_regs_pkg::IDX_IRQ_ENABLE: rd_data[daa_regs_pkg::IRQ_W-1:0] = irq_enable_reg;
      default: rd_data = '0;
    endcase
  end

  // Analog control decode.
  daa_regs_pkg::analog_ctrl_s analog_next;
  logic [2:0] tx_code;
  logic [2:0] rx_code;
  logic xfer_next;

  assign tx_code = gain_reg[daa_regs_pkg::GC_TX_ATTEN_LSB +: 3];
  assign rx_code = gain_reg[daa_regs_pkg::GC_RX_GAIN_LSB +: 3];
  assign analog_next.tx_mute = gain_reg[daa_regs_pkg::GC_TX_MUTE_BIT]; // [R12]
  assign analog_next.rx_mute = gain_reg[daa_regs_pkg::GC_RX_MUTE_BIT]; // [R14]
  // The legacy steps add on top of the field; software is expected to leave them clear.
  assign analog_next.tx_atten_db = 5'(step_db(tx_code) +
    (legacy_reg[0] ? daa_regs_pkg::LEGACY_TX_DB : 5'h00)); // [R13] [R4] [R6]
  assign analog_next.rx_gain_db = 5'(step_db(rx_code) +
    (legacy_reg[1] ? daa_regs_pkg::LEGACY_RX_DB : 5'h00)); // [R15] [R3] [R5]
  assign analog_next.mon_atten_tenths = mon_tenths(rx_code); // [R16]
  // Samples flow only after a finished check found the right part.
  assign xfer_next = pins_reg.line_enable && !check_pending && !check_busy && !check_fail; // [R11] [R10]

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_tx_mute <= 1'b0;
      o_rx_mute <= 1'b0;
      o_tx_atten_db <= '0;
      o_rx_gain_db <= '0;
      o_mon_atten_tenths <= '0;
      o_sample_xfer_en <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      o_tx_mute <= analog_next.tx_mute;
      o_rx_mute <= analog_next.rx_mute;
      o_tx_atten_db <= analog_next.tx_atten_db;
      o_rx_gain_db <= analog_next.rx_gain_db;
      o_mon_atten_tenths <= analog_next.mon_atten_tenths;
      o_sample_xfer_en <= xfer_next;
      o_irq <= |(irq_status_next & irq_enable_next);
    end
  end

endmodule // daa_gain_line_check_regs

/* File: bench/daa_regs_asserts.sv */
`timescale 1ns/1ps
module daa_regs_asserts
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Watched inputs
  input wire logic i_bready,
  input wire logic i_line_enable,
  // Watched outputs
  input wire logic o_awready,
  input wire logic o_arready,
  input wire logic o_bvalid,
  input wire logic o_rvalid,
  input wire logic [daa_regs_pkg::DATA_W-1:0] o_rdata,
  input wire logic o_tx_mute,
  input wire logic o_rx_mute,
  input wire logic [4:0] o_tx_atten_db,
  input wire logic [4:0] o_rx_gain_db,
  input wire logic [5:0] o_mon_atten_tenths,
  input wire logic o_sample_xfer_en,
  input wire logic o_irq
);
  default clocking dc @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  a_write_release: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready)
    else $error("write response not released");
  a_read_taken: assert property ($rose(o_rvalid) |-> $fell(o_arready))
    else $error("read answer without address take");
  a_write_refused: assert property (o_bvalid |-> !o_awready)
    else $error("write address ready while response pending");
  a_read_upper_zero: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_tx_atten_steps: assert property (o_tx_atten_db inside {5'h00, 5'h03, 5'h06, 5'h09, 5'h0c, 5'h0f})
    else $error("transmit attenuation off step");
  a_rx_gain_steps: assert property (o_rx_gain_db inside {5'h00, 5'h03, 5'h06, 5'h09, 5'h0c, 5'h0f, 5'h12})
    else $error("receive gain off step");
  a_mon_steps: assert property (o_mon_atten_tenths inside {6'h00, 6'h0a, 6'h16, 6'h23, 6'h32})
    else $error("monitor attenuation off step");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_tx_mute && !o_rx_mute && !o_irq && !o_sample_xfer_en)
    else $error("outputs not cleared by reset");
  a_xfer_cause: assert property ($rose(o_sample_xfer_en) |-> $past(i_line_enable, 3))
    else $error("transfer enabled without line enable");
  a_mute_on_write: assert property ($changed(o_tx_mute) |-> $past(o_bvalid))
    else $error("transmit mute moved without a write");
endmodule // daa_regs_asserts

bind daa_gain_line_check_regs daa_regs_asserts u_asserts
(
  .i_clock(i_clock),
  .i_rst_n(i_rst_n),
  .i_bready(i_bready),
  .i_line_enable(i_line_enable),
  .o_awready(o_awready),
  .o_arready(o_arready),
  .o_bvalid(o_bvalid),
  .o_rvalid(o_rvalid),
  .o_rdata(o_rdata),
  .o_tx_mute(o_tx_mute),
  .o_rx_mute(o_rx_mute),
  .o_tx_atten_db(o_tx_atten_db),
  .o_rx_gain_db(o_rx_gain_db),
  .o_mon_atten_tenths(o_mon_atten_tenths),
  .o_sample_xfer_en(o_sample_xfer_en),
  .o_irq(o_irq)
);

/* File: bench/axil_host.sv */
`timescale 1ns/1ps
module axil_host
(
  // Clock
  input wire logic i_clock,
  // Requests
  output logic [7:0] o_awaddr,
  output logic o_awvalid,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wvalid,
  output logic o_bready,
  output logic [7:0] o_araddr,
  output logic o_arvalid,
  output logic o_rready,
  // Answers
  input wire logic i_awready,
  input wire logic i_wready,
  input wire logic [1:0] i_bresp,
  input wire logic i_bvalid,
  input wire logic i_arready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp,
  input wire logic i_rvalid
);
  initial
  begin
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready} = '0;
  end
  // Each channel holds its payload until its own ready is sampled, since the slave may take them apart.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_clock);
    {o_awaddr, o_wdata, o_wstrb} <= {a, d, 4'hf};
    {o_awvalid, o_wvalid, o_bready} <= 3'b111;
    forever
    begin
      @(posedge i_clock);
      if (o_awvalid && i_awready)
        o_awvalid <= 1'b0;
      if (o_wvalid && i_wready)
        o_wvalid <= 1'b0;
      if (i_bvalid)
      begin
        r = i_bresp;
        o_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clock);
    o_araddr <= a;
    {o_arvalid, o_rready} <= 2'b11;
    forever
    begin
      @(posedge i_clock);
      if (o_arvalid && i_arready)
        o_arvalid <= 1'b0;
      if (i_rvalid)
      begin
        {d, r} = {i_rdata, i_rresp};
        o_rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule // axil_host

/* File: bench/test_daa_gain_line_check_regs.sv */
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module test_daa_gain_line_check_regs;
  typedef struct packed {logic [7:0] w; logic [4:0] tx; logic [4:0] rx; logic [5:0] mon;} row_s;
  row_s rows [8] = '{{8'h00, 5'h00, 5'h00, 6'h00}, {8'h19, 5'h03, 5'h03, 6'h0a}, {8'ha2, 5'h06, 5'h06, 6'h16},
    {8'h33, 5'h09, 5'h09, 6'h23}, {8'hcc, 5'h0c, 5'h0c, 6'h32}, {8'h5d, 5'h0c, 5'h0c, 6'h32},
    {8'h6e, 5'h0c, 5'h0c, 6'h32}, {8'hf7, 5'h0c, 5'h0c, 6'h32}};
  logic clk = 0, rst_n = 0, en = 0, ok = 0, intl = 1;
  logic [3:0] rev = 4'ha, wstrb;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic tx_mute, rx_mute, xfer, irq;
  logic [4:0] tx_db, rx_db;
  logic [5:0] mon;
  int fails = 0, comparisons = 0, n;
  initial forever #50 clk = ~clk;
  axil_host host (.i_clock(clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .o_wdata(wdata), .o_wstrb(wstrb),
    .o_wvalid(wvalid), .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid), .o_rready(rready),
    .i_awready(awready), .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .i_arready(arready),
    .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid));
  daa_gain_line_check_regs dut (.i_clock(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awprot(3'h0),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arprot(3'h0), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .i_line_enable(en), .i_line_part_ok(ok), .i_line_chip_intl_flag(intl),
    .i_line_chip_revision(rev), .o_tx_mute(tx_mute), .o_rx_mute(rx_mute), .o_tx_atten_db(tx_db),
    .o_rx_gain_db(rx_db), .o_mon_atten_tenths(mon), .o_sample_xfer_en(xfer), .o_irq(irq));
  task automatic w(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
    logic [1:0] rr;
    host.wr(a, dv, rr);
    `CHK(rr, er)
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    logic [31:0] dd;
    logic [1:0] rr;
    host.rd(a, dd, rr);
    `CHK(dd, ev)
    `CHK(rr, er)
  endtask
  // The result bit is only trusted once a read shows both pending and busy clear.
  task automatic run_check();
    d = '0;
    for (n = 0; n < 40 && !d[1]; n++) host.rd(8'h38, d, r);
    `CHK(d, 32'h06)
    for (n = 0; n < 40 && d[1]; n++) host.rd(8'h38, d, r);
  endtask
  task automatic conclude();
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #1000000;
    fails++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      w(8'h3c, {24'h0, rows[i].w}, 2'h0);
      rc(8'h3c, {24'h0, rows[i].w}, 2'h0);
      `CHK({tx_mute, rx_mute}, {rows[i].w[7], rows[i].w[3]})
      `CHK(tx_db, rows[i].tx)
      `CHK(rx_db, rows[i].rx)
      `CHK(mon, rows[i].mon)
    end
    $display("gain table done");
    w(8'h34, 32'hffffffff, 2'h0);
    w(8'h3c, 32'h11, 2'h0);
    rc(8'h34, 32'h6b, 2'h0);
    `CHK(tx_db, 5'h06)
    `CHK(rx_db, 5'h09)
    w(8'h34, 32'h0, 2'h0);
    w(8'h38, 32'hff, 2'h0);
    rc(8'h38, 32'h04, 2'h0);
    w(8'h80, 32'h1, 2'h2);
    rc(8'h80, 32'h0, 2'h2);
    $display("id and reserved done");
    w(8'h48, 32'h3, 2'h0);
    @(posedge clk);
    en <= 1'b1;
    run_check();
    `CHK(d, 32'h01)
    #250;
    `CHK({xfer, irq}, 2'b01)
    rc(8'h40, 32'h3, 2'h0);
    w(8'h48, 32'h0, 2'h0);
    #250;
    `CHK(irq, 1'b0)
    w(8'h48, 32'h2, 2'h0);
    #250;
    `CHK(irq, 1'b1)
    w(8'h44, 32'h3, 2'h0);
    rc(8'h40, 32'h0, 2'h0);
    `CHK(irq, 1'b0)
    $display("failed check done");
    @(posedge clk);
    {rst_n, en, ok, intl, rev} <= 8'h25;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h38, 32'h04, 2'h0);
    rc(8'h3c, 32'h0, 2'h0);
    rc(8'h34, 32'h14, 2'h0);
    `CHK({xfer, irq, tx_db}, 7'h0)
    w(8'h48, 32'h1, 2'h0);
    @(posedge clk);
    en <= 1'b1;
    run_check();
    `CHK(d, 32'h0)
    #250;
    `CHK({xfer, irq}, 2'b11)
    @(posedge clk);
    en <= 1'b0;
    #850;
    `CHK(xfer, 1'b0)
    @(posedge clk);
    en <= 1'b1;
    #1050;
    rc(8'h38, 32'h0, 2'h0);
    $display("reset and passed check done");
    conclude();
  end
endmodule // test_daa_gain_line_check_regs
